// ---- rtl/dws_pkg.sv ----
// Behaviour
// [R1] The error code word is read-only, flags data-memory-one banks 2..0 in bits 10..8, data-memory-zero banks 3..0 in bits 7..4, program memories one and zero in bits 3..2 and rate converters one and zero in bits 1..0, and resets to zero.
// [R2] A software error copies the 16-bit execute-stage program count into a read-write debug register that resets to zero.
// [R3] The watchdog count starts at the programmed start value and steps down by one per prescale interval of core clock cycles.
// [R4] Each new-frame jump back to the program start reloads the watchdog count with its start value.
// [R5] A watchdog count that reaches zero before a reload raises a watchdog error toward the error manager.
// [R6] The watchdog start value is a 13-bit read-write field in the low bits, resetting to zero, upper bits reserved.
// [R7] A 4-bit prescale code selects 64 cycles for code 0, doubling per code up to 131072 cycles for code 11, resetting to 0.
// [R8] The watchdog timeout in cycles is the prescale interval times the start value.
// [R9] One enable bit, resetting to zero, turns block interrupts off (0) or on (1).
// [R10] The block counter adds one on each new audio frame start pulse.
// [R11] When the block counter reaches the 16-bit block length, a block interrupt is raised and the counter returns to zero.
// [R12] The current program counter is readable through two registers, the upper part at index 0xF460.
// [R13] The error code word keeps only the first error after a clear and ignores later ones until the clear control toggles.
// [R14] The master error flag is sticky, set by an unmasked error and held until software clears it.
// [R15] A watchdog mask bit of one stops watchdog errors being reported; zero lets them through.
// [R16] Block interrupts arise only while enabled, and prescale codes above 11 act as code 11.
package dws_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CLEAR     = 16'hF421;
   localparam logic [15:0] IDX_WD_MASK   = 16'hF424;
   localparam logic [15:0] IDX_FLAG      = 16'hF427;
   localparam logic [15:0] IDX_CODE      = 16'hF428;
   localparam logic [15:0] IDX_EXEC_CNT  = 16'hF432;
   localparam logic [15:0] IDX_WD_START  = 16'hF443;
   localparam logic [15:0] IDX_WD_DIV    = 16'hF444;
   localparam logic [15:0] IDX_BLK_EN    = 16'hF450;
   localparam logic [15:0] IDX_BLK_LEN   = 16'hF451;
   localparam logic [15:0] IDX_PC_HIGH   = 16'hF460;
   localparam logic [15:0] IDX_PC_LOW    = 16'hF461;

   localparam int          ADDR_W        = 18;

   // Field positions and widths
   localparam int          WD_START_W    = 13;
   localparam int          WD_DIV_W      = 4;
   localparam int          FAULT_W       = 11;
   localparam int          POS_CODE_WD   = 12;
   localparam int          POS_CODE_SOFT = 15;
   localparam int          PC_W          = 24;

   // Reset values
   localparam logic [15:0] RST_WORD      = 16'h0000;

   // Prescale: base interval 64 = 1 << 6, top code 11
   localparam int          PRESC_BASE_SH = 6;
   localparam logic [3:0]  PRESC_MAX     = 4'hB;
   localparam int          PRESC_CNT_W   = 17;

   // Watchdog settings handed to the timer
   typedef struct packed {
      logic [WD_START_W-1:0] start_value;
      logic [WD_DIV_W-1:0]   step_code;
   } dws_wd_cfg_t;

   // Hardware fault sources, one pulse each
   typedef struct packed {
      logic [2:0] dmem1_bank;    // banks 2..0
      logic [3:0] dmem0_bank;    // banks 3..0
      logic       progmem_one;
      logic       progmem_zero;
      logic       rate_conv_one;
      logic       rate_conv_zero;
   } dws_fault_t;

endpackage

// ---- rtl/dws_wd_timer.sv ----
`timescale 1ns/100ps
module dws_wd_timer
   import dws_pkg::*;
(
   input  wire logic                  clk,        // Core clock
   input  wire logic                  rst_n,      // Synchronised reset
   input  wire logic                  ce,         // Clock enable
   input  wire logic                  reload,     // New frame start
   input  wire dws_wd_cfg_t           cfg,        // Start value and step code
   output logic [WD_START_W-1:0]      count,      // Current watchdog count
   output logic                       expire      // One-cycle expiry pulse
);

   typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_EXPIRED} dws_wd_state_t;

   dws_wd_state_t            state_r;
   logic [PRESC_CNT_W-1:0]   pcnt_r;
   logic [3:0]               code_sat;
   logic [PRESC_CNT_W-1:0]   interval_m1;
   logic                     tick;

   // Codes past the top entry saturate so the interval never wraps
   assign code_sat    = (cfg.step_code > PRESC_MAX) ? PRESC_MAX : cfg.step_code;   // [R16]
   // Shift amount is five bits wide: code 11 plus the base shift of six needs them
   assign interval_m1 = PRESC_CNT_W'((18'h00001 << (5'(code_sat) + 5'(PRESC_BASE_SH)))
                                     - 18'h00001);                                    // [R7]
   assign tick        = (state_r == WD_RUN) && (pcnt_r == interval_m1);

   // Prescale cycle counter, restarted by every reload
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pcnt_r <= '0;
      end else if (ce) begin
         if (reload || tick || state_r != WD_RUN)
            pcnt_r <= '0;
         else
            pcnt_r <= pcnt_r + 1'b1;                                   // [R3]
      end
   end

   // Down counter; timeout is interval times start value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= WD_IDLE;
         count   <= '0;
         expire  <= 1'b0;
      end else if (ce) begin
         expire <= 1'b0;
         if (reload) begin
            count   <= cfg.start_value;                                 // [R4]
            state_r <= (cfg.start_value != '0) ? WD_RUN : WD_IDLE;
         end else begin
            unique case (state_r)
               WD_IDLE: state_r <= WD_IDLE;
               WD_RUN: begin
                  if (tick) begin
                     count <= count - 1'b1;                             // [R3] [R8]
                     if (count == 13'h0001) begin
                        expire  <= 1'b1;                                // [R5]
                        state_r <= WD_EXPIRED;
                     end
                  end
               end
               WD_EXPIRED: state_r <= WD_EXPIRED;
            endcase
         end
      end
   end

   AST_WD_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      ce && reload |=> count == $past(cfg.start_value))
      else $error("watchdog not reloaded with start value");

   AST_WD_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      expire |-> count == 13'h0000 && $past(count) == 13'h0001 && !$past(reload))
      else $error("watchdog expired from wrong count");

   AST_WD_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      ce && !reload && !tick |=> $stable(count))
      else $error("watchdog count moved without a step");

endmodule

// ---- rtl/dws_supervisor.sv ----
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module dws_supervisor
   import dws_pkg::*;
(
   input  wire logic                  clk,            // Core clock, 200 MHz
   input  wire logic                  rst_n,          // Asynchronous reset, active low
   input  wire logic                  ce,             // Clock enable, freezes state when low
   // APB slave
   input  wire logic                  psel,           // Slave select
   input  wire logic                  penable,        // Access phase
   input  wire logic                  pwrite,         // Write direction
   input  wire logic [ADDR_W-1:0]     paddr,          // Byte address
   input  wire logic [31:0]           pwdata,         // Write data
   output logic [31:0]                prdata,         // Read data, registered
   output logic                       pready,         // Transfer done
   output logic                       pslverr,        // Unmapped address
   // Core side
   input  wire logic                  frame_start,    // New audio frame pulse
   input  wire logic [PC_W-1:0]       pc_value,       // Current program counter
   input  wire logic [15:0]           exec_pc,        // Execute-stage program count
   input  wire logic                  soft_err,       // Software error pulse
   input  wire dws_fault_t            faults,         // Hardware fault pulses
   output logic                       wd_error,       // Reported watchdog error pulse
   output logic                       block_irq,      // Block interrupt pulse
   output logic                       error_flag,     // Sticky master error flag
   output logic [WD_START_W-1:0]      wd_count        // Watchdog count view
);

   logic [1:0]              rst_pipe_r;
   logic                    rst_sync_n;
   logic                    setup;
   logic                    access;
   logic                    wr_en;
   logic [15:0]             idx;
   logic                    hit;
   logic                    clear_r;
   logic                    clear_evt;
   logic                    wd_mask_r;
   logic [15:0]             code_r;
   logic [15:0]             code_evt;
   logic                    flag_nxt;
   logic [15:0]             exec_cnt_r;
   dws_wd_cfg_t             wd_cfg_r;
   logic                    blk_en_r;
   logic [15:0]             blk_len_r;
   logic [15:0]             blk_cnt_r;
   logic [15:0]             blk_cnt_nxt;
   logic                    wd_expire;
   logic [15:0]             rd_word;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rst_pipe_r <= 2'b00;
      else
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe_r[1];

   // APB decode: word index is the byte address over four
   assign idx    = paddr[ADDR_W-1:2];
   assign setup  = psel && !penable && ce;
   assign access = psel && penable;
   assign hit    = (idx == IDX_CLEAR)    || (idx == IDX_WD_MASK) || (idx == IDX_FLAG)   ||
                   (idx == IDX_CODE)     || (idx == IDX_EXEC_CNT) ||
                   (idx == IDX_WD_START) || (idx == IDX_WD_DIV)  || (idx == IDX_BLK_EN) ||
                   (idx == IDX_BLK_LEN)  || (idx == IDX_PC_HIGH) || (idx == IDX_PC_LOW);
   // Zero wait states, but held off while the clock enable is low
   assign pready  = access && ce;
   assign pslverr = access && ce && !hit;
   assign wr_en   = access && ce && pwrite && hit;

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_word = RST_WORD;
      unique case (1'b1)
         idx == IDX_CLEAR:    rd_word = {15'h0000, clear_r};
         idx == IDX_WD_MASK:  rd_word = {15'h0000, wd_mask_r};
         idx == IDX_FLAG:     rd_word = {15'h0000, error_flag};
         idx == IDX_CODE:     rd_word = code_r;                                  // [R1]
         idx == IDX_EXEC_CNT: rd_word = exec_cnt_r;                              // [R2]
         idx == IDX_WD_START: rd_word = {3'h0, wd_cfg_r.start_value};            // [R6]
         idx == IDX_WD_DIV:   rd_word = {12'h000, wd_cfg_r.step_code};           // [R7]
         idx == IDX_BLK_EN:   rd_word = {15'h0000, blk_en_r};                    // [R9]
         idx == IDX_BLK_LEN:  rd_word = blk_len_r;
         idx == IDX_PC_HIGH:  rd_word = {8'h00, pc_value[PC_W-1:16]};            // [R12]
         idx == IDX_PC_LOW:   rd_word = pc_value[15:0];                          // [R12]
         default:             rd_word = RST_WORD;
      endcase
   end

   // Read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         prdata <= 32'h00000000;
      else if (setup)
         prdata <= {16'h0000, rd_word};
   end

   // Plain control registers written by software
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         clear_r   <= 1'b0;
         wd_mask_r <= 1'b0;
         wd_cfg_r  <= '0;
         blk_en_r  <= 1'b0;
         blk_len_r <= RST_WORD;
      end else if (wr_en) begin
         if (idx == IDX_CLEAR)    clear_r              <= pwdata[0];
         if (idx == IDX_WD_MASK)  wd_mask_r            <= pwdata[0];             // [R15]
         if (idx == IDX_WD_START) wd_cfg_r.start_value <= pwdata[WD_START_W-1:0]; // [R6]
         if (idx == IDX_WD_DIV)   wd_cfg_r.step_code   <= pwdata[WD_DIV_W-1:0];  // [R7]
         if (idx == IDX_BLK_EN)   blk_en_r             <= pwdata[0];             // [R9]
         if (idx == IDX_BLK_LEN)  blk_len_r            <= pwdata[15:0];
      end
   end

   // A clear is any change of the clear bit, in either direction
   assign clear_evt = wr_en && (idx == IDX_CLEAR) && (pwdata[0] != clear_r);

   // Events reaching the manager; a masked watchdog never shows here
   always_comb begin
      code_evt                = {5'h00, faults};                                 // [R1]
      code_evt[POS_CODE_WD]   = wd_expire && !wd_mask_r;                         // [R15]
      code_evt[POS_CODE_SOFT] = soft_err;
   end

   // First error wins; an event in the clearing cycle is kept, not lost
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         code_r <= RST_WORD;                                                     // [R1]
      end else if (ce) begin
         if (code_evt != RST_WORD && (code_r == RST_WORD || clear_evt))
            code_r <= code_evt;                                                  // [R13]
         else if (clear_evt)
            code_r <= RST_WORD;
      end
   end

   // Sticky master flag, set dominates clear
   assign flag_nxt = (code_evt != RST_WORD) || (error_flag && !clear_evt);      // [R14]
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         error_flag <= 1'b0;
      else if (ce)
         error_flag <= flag_nxt;
   end

   // Program count capture; a capture beats a software write
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         exec_cnt_r <= RST_WORD;
      else if (ce && soft_err)
         exec_cnt_r <= exec_pc;                                                  // [R2]
      else if (wr_en && idx == IDX_EXEC_CNT)
         exec_cnt_r <= pwdata[15:0];
   end

   // Watchdog timer reloaded at every frame start
   dws_wd_timer u_wd (
      .clk    (clk),
      .rst_n  (rst_sync_n),
      .ce     (ce),
      .reload (frame_start),                                                     // [R4]
      .cfg    (wd_cfg_r),
      .count  (wd_count),
      .expire (wd_expire)
   );

   // Report the expiry outward unless masked
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         wd_error <= 1'b0;
      else if (ce)
         wd_error <= wd_expire && !wd_mask_r;                                    // [R5] [R15]
   end

   // Block counter; held at zero while disabled so a re-enable starts clean
   assign blk_cnt_nxt = blk_cnt_r + 16'h0001;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         blk_cnt_r <= RST_WORD;
         block_irq <= 1'b0;
      end else if (ce) begin
         block_irq <= 1'b0;
         if (!blk_en_r) begin
            blk_cnt_r <= RST_WORD;                                               // [R16]
         end else if (frame_start) begin
            if (blk_cnt_nxt == blk_len_r) begin
               blk_cnt_r <= RST_WORD;                                            // [R11]
               block_irq <= 1'b1;                                                // [R11] [R16]
            end else begin
               blk_cnt_r <= blk_cnt_nxt;                                         // [R10]
            end
         end
      end
   end

   AST_CODE_FIRST: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R13]
      ce && code_r != 16'h0000 && !clear_evt |=> $stable(code_r))
      else $error("error code changed without a clear");

   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R14]
      ce && error_flag && !clear_evt |=> error_flag)
      else $error("error flag dropped without a clear");

   AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R14]
      ce && code_evt != 16'h0000 |=> error_flag && code_r != 16'h0000)
      else $error("error not logged");

   AST_WD_MASKED: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R15]
      wd_error |-> !$past(wd_mask_r) && $past(wd_expire))
      else $error("watchdog error reported while masked");

   AST_EXEC_CAP: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R2]
      ce && soft_err |=> exec_cnt_r == $past(exec_pc))
      else $error("execute count not captured");

   AST_BLK_IRQ: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R11]
      block_irq |-> blk_cnt_r == 16'h0000 && $past(blk_en_r) && $past(frame_start)
                    && $past(blk_cnt_r) + 16'h0001 == $past(blk_len_r))
      else $error("block interrupt at wrong count");

   AST_BLK_COUNT: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R10]
      ce && blk_en_r && frame_start && blk_cnt_r + 16'h0001 != blk_len_r
      |=> blk_cnt_r == $past(blk_cnt_r) + 16'h0001)
      else $error("block counter did not step");

   AST_APB_UNMAP: assert property (@(posedge clk) disable iff (!rst_sync_n)
      pslverr |-> pready && !hit)
      else $error("error answer on a mapped address");

endmodule

// ---- testbench/dws_supervisor_test.sv ----
`timescale 1ns/100ps
module dws_supervisor_test;
   import dws_pkg::*;

   logic                  clk, rst_n, ce, psel, penable, pwrite;
   logic [ADDR_W-1:0]     paddr;
   logic [31:0]           pwdata, prdata;
   logic                  pready, pslverr, frame_start, soft_err;
   logic [PC_W-1:0]       pc_value;
   logic [15:0]           exec_pc;
   dws_fault_t            faults;
   logic                  wd_error, block_irq, error_flag;
   logic [WD_START_W-1:0] wd_count;
   int                    error_cnt, n_checks, irq_cnt, wd_cnt;
   logic                  clr_val;
   logic [31:0]           rd;
   logic                  err;

   dws_supervisor DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_start(frame_start), .pc_value(pc_value), .exec_pc(exec_pc),
      .soft_err(soft_err), .faults(faults), .wd_error(wd_error), .block_irq(block_irq),
      .error_flag(error_flag), .wd_count(wd_count));

   // 200 MHz core clock
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // Pulse counters; pulses last one cycle so polling could miss them
   always @(posedge clk) begin
      if (block_irq === 1'b1) irq_cnt++;
      if (wd_error === 1'b1) wd_cnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // APB master: setup, then hold access until pready is sampled high
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // No wait limit is set; a slave that never answers is caught by the run watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(rd, exp);
   endtask

   // Clear toggles bit 0 from its current value
   task automatic clear_errors();
      clr_val = ~clr_val;
      apb(1'b1, IDX_CLEAR, {31'h0, clr_val});
   endtask

   task automatic frame();
      @(posedge clk) frame_start <= 1'b1;
      @(posedge clk) frame_start <= 1'b0;
   endtask

   // Reset values and an unmapped address
   task automatic t_reset();
      rd_chk(IDX_CODE, 32'h0);
      rd_chk(IDX_EXEC_CNT, 32'h0);
      rd_chk(IDX_WD_START, 32'h0);
      rd_chk(IDX_WD_DIV, 32'h0);
      rd_chk(IDX_BLK_EN, 32'h0);
      rd_chk(IDX_BLK_LEN, 32'h0);
      rd_chk(IDX_FLAG, 32'h0);
      apb(1'b1, 16'hF400, 32'h1234);
      check(err, 1'b1);
      apb(1'b1, IDX_WD_START, 32'hFFFF_FFFF);
      rd_chk(IDX_WD_START, 32'h1FFF);
      apb(1'b1, IDX_WD_START, 32'h0);
   endtask

   // Software error capture, first-error hold and sticky flag
   task automatic t_soft();
      @(posedge clk) begin soft_err <= 1'b1; exec_pc <= 16'hBEEF; end
      @(posedge clk) begin soft_err <= 1'b0; exec_pc <= 16'h1111; end
      @(posedge clk) faults <= dws_fault_t'(11'h001);
      @(posedge clk) faults <= dws_fault_t'(11'h000);
      rd_chk(IDX_EXEC_CNT, 32'hBEEF);
      rd_chk(IDX_CODE, 32'h8000);
      check(error_flag, 1'b1);
      repeat (5) @(posedge clk);
      check(error_flag, 1'b1);
      apb(1'b1, IDX_CODE, 32'hFFFF);
      rd_chk(IDX_CODE, 32'h8000);
      clear_errors();
      rd_chk(IDX_CODE, 32'h0);
      check(error_flag, 1'b0);
      apb(1'b1, IDX_EXEC_CNT, 32'h5A5A);
      rd_chk(IDX_EXEC_CNT, 32'h5A5A);
   endtask

   // Each hardware fault lands in its own bit
   task automatic t_faults();
      for (int i = 0; i < FAULT_W; i++) begin
         @(posedge clk) faults <= dws_fault_t'(11'h001 << i);
         @(posedge clk) faults <= dws_fault_t'(11'h000);
         rd_chk(IDX_CODE, 32'h1 << i);
         clear_errors();
      end
   endtask

   // Cycles from the loading frame edge to the reported error
   task automatic wd_time(input int exp);
      int n;
      n = 0;
      frame();
      // Look just after each edge, once the registered pulse has settled
      while (wd_error !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n, exp);
      if (n >= 3000) tally_and_finish();
   endtask

   task automatic t_watchdog();
      apb(1'b1, IDX_WD_START, 32'h3);
      wd_time(3 * 64 + 1);
      rd_chk(IDX_CODE, 32'h1000);
      clear_errors();
      apb(1'b1, IDX_WD_DIV, 32'h1);
      apb(1'b1, IDX_WD_START, 32'h2);
      wd_time(2 * 128 + 1);
      apb(1'b1, IDX_WD_DIV, 32'h0);
      apb(1'b1, IDX_WD_START, 32'h3);
      wd_cnt = 0;
      frame();
      repeat (150) @(posedge clk);
      check(wd_count, 13'h1);
      wd_time(3 * 64 + 1);
      repeat (2) @(posedge clk);
      check(wd_cnt, 1);
      clear_errors();
      apb(1'b1, IDX_WD_MASK, 32'h1);
      wd_cnt = 0;
      frame();
      repeat (300) @(posedge clk);
      check(wd_cnt, 0);
      rd_chk(IDX_CODE, 32'h0);
      check(error_flag, 1'b0);
      apb(1'b1, IDX_WD_MASK, 32'h0);
      apb(1'b1, IDX_WD_START, 32'h0);
      clear_errors();
   endtask

   // Block interrupt every length frames, only when enabled
   task automatic t_block();
      apb(1'b1, IDX_BLK_LEN, 32'h3);
      irq_cnt = 0;
      repeat (6) frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 0);
      apb(1'b1, IDX_BLK_EN, 32'h1);
      rd_chk(IDX_BLK_EN, 32'h1);
      repeat (2) frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 0);
      frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 1);
      repeat (3) frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 2);
      apb(1'b1, IDX_BLK_EN, 32'h0);
   endtask

   // Clock enable low freezes the block counter; a frame then is lost
   task automatic t_ce();
      apb(1'b1, IDX_BLK_LEN, 32'h1);
      apb(1'b1, IDX_BLK_EN, 32'h1);
      irq_cnt = 0;
      @(posedge clk) ce <= 1'b0;
      frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 0);
      ce <= 1'b1;
      frame();
      repeat (3) @(posedge clk);
      check(irq_cnt, 1);
      apb(1'b1, IDX_BLK_EN, 32'h0);
   endtask

   // Program counter readback, writes to it ignored
   task automatic t_pc();
      pc_value <= 24'hABCDEF;
      rd_chk(IDX_PC_HIGH, 32'h00AB);
      rd_chk(IDX_PC_LOW, 32'hCDEF);
      apb(1'b1, IDX_PC_HIGH, 32'h0055);
      check(err, 1'b0);
      rd_chk(IDX_PC_HIGH, 32'h00AB);
   endtask

   // Watchdog on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      error_cnt = 0; n_checks = 0; irq_cnt = 0; wd_cnt = 0; clr_val = 1'b0;
      rst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; frame_start = 1'b0; soft_err = 1'b0;
      pc_value = '0; exec_pc = '0; faults = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_soft();
      t_faults();
      t_watchdog();
      t_block();
      t_ce();
      t_pc();
      tally_and_finish();
   end
endmodule
